/* File: src/cwg_map.vh */
// register offsets, field positions, mode codes and reset values of the waveform unit
`ifndef CWG_MAP_VH
`define CWG_MAP_VH

`define CWG_ADDR_W 4
`define CWG_DATA_W 8

`define CWG_ADDR_CTRL 4'h0
`define CWG_ADDR_POL 4'h1
`define CWG_ADDR_STEER 4'h2
`define CWG_ADDR_DBR 4'h3
`define CWG_ADDR_DBF 4'h4
`define CWG_ADDR_STAT 4'h5

`define CWG_CTRL_EN 7
`define CWG_CTRL_LD 6
`define CWG_CTRL_MODE_HI 2
`define CWG_CTRL_MODE_LO 0

`define CWG_STEER_STR_HI 3
`define CWG_STEER_STR_LO 0
`define CWG_STEER_LVL_HI 7
`define CWG_STEER_LVL_LO 4

`define CWG_MODE_W 3
`define CWG_MODE_ASYNC 3'h0
`define CWG_MODE_SYNC 3'h1
`define CWG_MODE_FWD 3'h2
`define CWG_MODE_REV 3'h3
`define CWG_MODE_HALF 3'h4
`define CWG_MODE_PUSH 3'h5

`define CWG_DB_W 6
`define CWG_DB_MAX 6'h3F

`define CWG_RST_MODE 3'h0
`define CWG_RST_NIB 4'h0
`define CWG_RST_BYTE 8'h00
`define CWG_RST_DB 6'h00

`endif

/* File: src/complementary_wave_unit.v */
// complementary waveform unit: mode steering, dead band, polarity and shutdown of four outputs
`timescale 1ns/1ps
`include "cwg_map.vh"

module complementary_wave_unit #(
  parameter DB_W = `CWG_DB_W
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_ce,
  input wire [`CWG_ADDR_W-1:0] i_addr,
  input wire [`CWG_DATA_W-1:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [`CWG_DATA_W-1:0] o_rdata,
  input wire i_data,
  input wire i_shutdown,
  output wire o_out_a,
  output wire o_out_b,
  output wire o_out_c,
  output wire o_out_d
);

  // software-visible state, then the hidden dead-band buffers and load arming flag
  reg en_r;
  reg [`CWG_MODE_W-1:0] mode_r;
  reg [3:0] pol_r;
  reg [3:0] steer_r;
  reg [3:0] level_r;
  reg [DB_W-1:0] dbr_r;
  reg [DB_W-1:0] dbf_r;
  reg [DB_W-1:0] dbr_buf_r;
  reg [DB_W-1:0] dbf_buf_r;
  reg ld_r;
  reg ld_armed_r;

  // waveform state
  reg data_d_r;
  reg [DB_W-1:0] rise_cnt_r;
  reg [DB_W-1:0] fall_cnt_r;
  reg pp_r;
  reg dir_r;
  reg fb_wait_r;
  reg [DB_W-1:0] fb_cnt_r;
  reg [3:0] steer_act_r;
  reg [3:0] out_r;

  wire wr_ctrl;
  wire wr_dbr;
  wire wr_dbf;
  wire rise;
  wire fall;
  wire fb_mode;
  wire dir_sw;
  wire dir_eff;
  wire [DB_W-1:0] fb_limit;
  wire [DB_W-1:0] fb_cnt_cur;
  wire fb_hold;
  wire db_load;
  wire pp_sel;
  wire a_hb;
  wire b_hb;
  wire [3:0] steer_use;

  reg [3:0] raw;
  reg [3:0] pol_mask;
  reg [`CWG_DATA_W-1:0] rd_nxt;

  assign wr_ctrl = i_wr & (i_addr == `CWG_ADDR_CTRL);
  assign wr_dbr = i_wr & (i_addr == `CWG_ADDR_DBR);
  assign wr_dbf = i_wr & (i_addr == `CWG_ADDR_DBF);

  assign rise = i_data & ~data_d_r;
  assign fall = ~i_data & data_d_r;

  // while enabled, buffered dead-band values move only on the rise after the fall that follows a load request
  assign db_load = en_r & ld_armed_r & rise;

  // turn-on of A waits rise count, turn-on of B waits fall count; the counters
  // saturate so a held level never wraps and retriggers a second delay
  assign a_hb = i_data & (rise_cnt_r >= dbr_buf_r);
  assign b_hb = ~i_data & (fall_cnt_r >= dbf_buf_r);

  // the rising pulse itself already belongs to the next output
  assign pp_sel = rise ? ~pp_r : pp_r;

  assign fb_mode = (mode_r == `CWG_MODE_FWD) | (mode_r == `CWG_MODE_REV);
  // a pending direction is taken only at an input rise
  assign dir_sw = en_r & fb_mode & rise & (mode_r[0] != dir_r);
  assign dir_eff = dir_sw ? mode_r[0] : dir_r;
  // reverse uses the rise count on B, forward the fall count on D
  assign fb_limit = dir_eff ? dbr_buf_r : dbf_buf_r;
  assign fb_cnt_cur = dir_sw ? {DB_W{1'b0}} : fb_cnt_r;
  // the count runs on even if the input falls, so a short first pulse is simply lost
  assign fb_hold = (dir_sw | fb_wait_r) & (fb_cnt_cur < fb_limit);

  // asynchronous steering bypasses the held copy so a write acts on the next cycle
  assign steer_use = (mode_r == `CWG_MODE_ASYNC) ? steer_r :
                     (rise ? steer_r : steer_act_r);

  always @* begin
    raw = 4'h0;
    pol_mask = 4'hF;
    case (mode_r)
      `CWG_MODE_HALF: begin
        raw = {b_hb, a_hb, b_hb, a_hb};
      end
      `CWG_MODE_PUSH: begin
        raw[0] = i_data & ~pp_sel;
        raw[1] = i_data & pp_sel;
        raw[2] = raw[0];
        raw[3] = raw[1];
      end
      `CWG_MODE_ASYNC, `CWG_MODE_SYNC: begin
        raw = (steer_use & {4{i_data}}) | (~steer_use & level_r);
        pol_mask = steer_use;
      end
      `CWG_MODE_FWD, `CWG_MODE_REV: begin
        if (dir_eff) begin
          raw[2] = 1'b1;
          raw[1] = i_data & ~fb_hold;
        end else begin
          raw[0] = 1'b1;
          raw[3] = i_data & ~fb_hold;
        end
      end
      default: begin
        raw = 4'h0;
      end
    endcase
  end

  // per-output polarity and override; shutdown and disable force zero regardless of polarity
  // override: each unsteered output takes its own level from level_r, with no polarity applied
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_out
      always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          out_r[gi] <= 1'b0;
        end else if (i_ce) begin
          if (!en_r || i_shutdown) begin
            out_r[gi] <= 1'b0;
          end else begin
            out_r[gi] <= raw[gi] ^ (pol_r[gi] & pol_mask[gi]);
          end
        end
      end
    end
  endgenerate

  assign o_out_a = out_r[0];
  assign o_out_b = out_r[1];
  assign o_out_c = out_r[2];
  assign o_out_d = out_r[3];

  // register file
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en_r <= 1'b0;
      mode_r <= `CWG_RST_MODE;
      pol_r <= `CWG_RST_NIB;
      steer_r <= `CWG_RST_NIB;
      level_r <= `CWG_RST_NIB;
      dbr_r <= `CWG_RST_DB;
      dbf_r <= `CWG_RST_DB;
    end else if (i_ce && i_wr) begin
      case (i_addr)
        `CWG_ADDR_CTRL: begin
          en_r <= i_wdata[`CWG_CTRL_EN];
          // mode may change at any time; only full-bridge swaps are safe while enabled
          mode_r <= i_wdata[`CWG_CTRL_MODE_HI:`CWG_CTRL_MODE_LO];
        end
        `CWG_ADDR_POL: begin
          pol_r <= i_wdata[3:0];
        end
        `CWG_ADDR_STEER: begin
          steer_r <= i_wdata[`CWG_STEER_STR_HI:`CWG_STEER_STR_LO];
          level_r <= i_wdata[`CWG_STEER_LVL_HI:`CWG_STEER_LVL_LO];
        end
        `CWG_ADDR_DBR: begin
          dbr_r <= i_wdata[DB_W-1:0];
        end
        `CWG_ADDR_DBF: begin
          dbf_r <= i_wdata[DB_W-1:0];
        end
        default: begin
          en_r <= en_r;
        end
      endcase
    end
  end

  // dead-band double buffer and load request
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dbr_buf_r <= `CWG_RST_DB;
      dbf_buf_r <= `CWG_RST_DB;
      ld_r <= 1'b0;
      ld_armed_r <= 1'b0;
    end else if (i_ce) begin
      if (!en_r) begin
        // disabled: the live count follows every write with no waiting
        if (wr_dbr) begin
          dbr_buf_r <= i_wdata[DB_W-1:0];
        end
        if (wr_dbf) begin
          dbf_buf_r <= i_wdata[DB_W-1:0];
        end
      end else if (db_load) begin
        dbr_buf_r <= dbr_r;
        dbf_buf_r <= dbf_r;
      end
      // a request written with the enable bit low is dropped: the buffers already track writes
      // a fresh request in the load cycle survives the clear
      if (wr_ctrl && i_wdata[`CWG_CTRL_LD] && i_wdata[`CWG_CTRL_EN]) begin
        ld_r <= 1'b1;
      end else if (db_load || !en_r) begin
        ld_r <= 1'b0;
      end
      if (db_load || !en_r) begin
        ld_armed_r <= 1'b0;
      end else if (ld_r && fall) begin
        ld_armed_r <= 1'b1;
      end
    end
  end

  // dead-band counters: count input-level cycles from zero, saturating at the top
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      data_d_r <= 1'b0;
      rise_cnt_r <= {DB_W{1'b0}};
      fall_cnt_r <= {DB_W{1'b0}};
    end else if (i_ce) begin
      data_d_r <= i_data;
      if (!i_data) begin
        rise_cnt_r <= {DB_W{1'b0}};
      end else if (rise_cnt_r != {DB_W{1'b1}}) begin
        rise_cnt_r <= rise_cnt_r + 1'b1;
      end
      if (i_data) begin
        fall_cnt_r <= {DB_W{1'b0}};
      end else if (fall_cnt_r != {DB_W{1'b1}}) begin
        fall_cnt_r <= fall_cnt_r + 1'b1;
      end
    end
  end

  // push-pull sequencer; reset state means the next pulse lands on A
  // a shutdown mid-sequence restarts on A, even when the last pulse before it was also on A
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pp_r <= 1'b1;
    end else if (i_ce) begin
      if (!en_r || i_shutdown) begin
        pp_r <= 1'b1;
      end else if (mode_r == `CWG_MODE_PUSH && rise) begin
        pp_r <= ~pp_r;
      end
    end
  end

  // full-bridge direction and direction-switch dead band
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dir_r <= 1'b0;
      fb_wait_r <= 1'b0;
      fb_cnt_r <= {DB_W{1'b0}};
    end else if (i_ce) begin
      if (!en_r) begin
        // enabling straight into either direction needs no switch delay
        // follow the mode being written so enabling straight into reverse starts reversed
        dir_r <= wr_ctrl ? i_wdata[`CWG_CTRL_MODE_LO] : mode_r[0];
        fb_wait_r <= 1'b0;
        fb_cnt_r <= {DB_W{1'b0}};
      end else if (dir_sw) begin
        dir_r <= mode_r[0];
        fb_wait_r <= (fb_limit != {DB_W{1'b0}});
        fb_cnt_r <= {{(DB_W-1){1'b0}}, 1'b1};
      end else if (fb_wait_r) begin
        if (fb_cnt_r >= fb_limit) begin
          fb_wait_r <= 1'b0;
        end else begin
          fb_cnt_r <= fb_cnt_r + 1'b1;
        end
      end
    end
  end

  // steering copy used by synchronous steering between input rises
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      steer_act_r <= `CWG_RST_NIB;
    end else if (i_ce) begin
      if (!en_r || mode_r == `CWG_MODE_ASYNC || rise) begin
        steer_act_r <= steer_r;
      end
    end
  end

  // read path: data stands only in the cycle after the strobe
  // status shows the pins as driven, so software sees polarity already applied
  always @* begin
    rd_nxt = `CWG_RST_BYTE;
    case (i_addr)
      `CWG_ADDR_CTRL: begin
        rd_nxt[`CWG_CTRL_EN] = en_r;
        rd_nxt[`CWG_CTRL_LD] = ld_r;
        rd_nxt[`CWG_CTRL_MODE_HI:`CWG_CTRL_MODE_LO] = mode_r;
      end
      `CWG_ADDR_POL: begin
        rd_nxt[3:0] = pol_r;
      end
      `CWG_ADDR_STEER: begin
        rd_nxt = {level_r, steer_r};
      end
      `CWG_ADDR_DBR: begin
        rd_nxt[DB_W-1:0] = dbr_r;
      end
      `CWG_ADDR_DBF: begin
        rd_nxt[DB_W-1:0] = dbf_r;
      end
      `CWG_ADDR_STAT: begin
        rd_nxt = {i_shutdown, fb_wait_r, dir_r, pp_r, out_r};
      end
      default: begin
        rd_nxt = `CWG_RST_BYTE;
      end
    endcase
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= `CWG_RST_BYTE;
    end else if (i_ce) begin
      if (i_rd) begin
        o_rdata <= rd_nxt;
      end else begin
        // idle value is zero so a stale word is never taken for a fresh read
        o_rdata <= `CWG_RST_BYTE;
      end
    end
  end

endmodule

/* File: testbench/wave_unit_checker.sv */
// concurrent checks on the ports of the waveform unit
`timescale 1ns/1ps
`include "cwg_map.vh"
module wave_unit_checker #(
  parameter DB_W = `CWG_DB_W
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_ce,
  input wire [`CWG_ADDR_W-1:0] i_addr,
  input wire [`CWG_DATA_W-1:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [`CWG_DATA_W-1:0] o_rdata,
  input wire i_data,
  input wire i_shutdown,
  input wire o_out_a,
  input wire o_out_b,
  input wire o_out_c,
  input wire o_out_d
);
  logic en_r;
  logic [2:0] mode_r;
  logic [3:0] pol_r;
  logic [7:0] steer_r;
  logic [1:0] quiet_r;
  wire [3:0] outs = {o_out_d, o_out_c, o_out_b, o_out_a};
  wire [3:0] raw = outs ^ pol_r;
  wire steady = quiet_r == 2'h3;
  wire fb = en_r && mode_r[2:1] == 2'h1;
  wire hp = en_r && (mode_r == `CWG_MODE_HALF || mode_r == `CWG_MODE_PUSH);
  // settings mirrored from the bus; three quiet cycles cover register and output stages
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en_r <= 1'b0;
      mode_r <= `CWG_RST_MODE;
      pol_r <= `CWG_RST_NIB;
      steer_r <= `CWG_RST_BYTE;
      quiet_r <= 2'h0;
    end else begin
      if (i_ce && i_wr && i_addr == `CWG_ADDR_CTRL) begin
        en_r <= i_wdata[`CWG_CTRL_EN];
        mode_r <= i_wdata[`CWG_CTRL_MODE_HI:`CWG_CTRL_MODE_LO];
      end
      if (i_ce && i_wr && i_addr == `CWG_ADDR_POL) pol_r <= i_wdata[3:0];
      if (i_ce && i_wr && i_addr == `CWG_ADDR_STEER) steer_r <= i_wdata;
      if (!i_ce || (i_wr && i_addr <= `CWG_ADDR_STEER)) quiet_r <= 2'h0;
      else if (!steady) quiet_r <= quiet_r + 2'h1;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence shut_s;
    i_ce && i_shutdown;
  endsequence
  sequence no_read_s;
    i_ce && !(i_rd && i_addr <= `CWG_ADDR_STAT);
  endsequence
  sequence fb_clean_s;
    steady && fb && !$past(i_shutdown) && !$past(i_shutdown, 2);
  endsequence
  AST_SHUTDOWN_ZERO: assert property (shut_s |=> outs == 4'h0)
    else $error("outputs not cleared by shutdown");
  AST_DISABLED_ZERO: assert property (steady && !en_r |-> outs == 4'h0)
    else $error("outputs driven while disabled");
  AST_ASYNC_STEER: assert property (steady && en_r && mode_r == `CWG_MODE_ASYNC
    && !$past(i_shutdown) |-> outs == ((steer_r[3:0] & ({4{$past(i_data)}} ^ pol_r))
    | (~steer_r[3:0] & steer_r[7:4])))
    else $error("steered outputs wrong");
  AST_BRIDGE_COPY: assert property (steady && hp && !$past(i_shutdown)
    |-> raw[2] == raw[0] && raw[3] == raw[1])
    else $error("outputs c d do not copy a b");
  AST_LEG_EXCLUSIVE: assert property (steady && (hp || fb) && !$past(i_shutdown)
    |-> !(raw[0] && raw[1]) && !(raw[2] && raw[3]))
    else $error("both switches of a leg active");
  AST_FB_STATIC: assert property (fb_clean_s |-> raw[0] != raw[2] && !(raw[1] && raw[3]))
    else $error("full bridge static outputs wrong");
  AST_DIR_AT_RISE: assert property (fb_clean_s ##0 $changed(o_out_a)
    |-> $past(i_data) && !$past(i_data, 2))
    else $error("direction changed away from an input rise");
  AST_READ_IDLE: assert property (no_read_s |=> o_rdata == 8'h00)
    else $error("read data not zero outside a read");
endmodule

bind complementary_wave_unit wave_unit_checker #(
  .DB_W(DB_W)
) wave_unit_checker_inst (
  .i_clk(i_clk),
  .i_rst_n(i_rst_n),
  .i_ce(i_ce),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .i_wr(i_wr),
  .i_rd(i_rd),
  .o_rdata(o_rdata),
  .i_data(i_data),
  .i_shutdown(i_shutdown),
  .o_out_a(o_out_a),
  .o_out_b(o_out_b),
  .o_out_c(o_out_c),
  .o_out_d(o_out_d)
);

/* File: testbench/power_switch_model.sv */
// behavioural model of the four power switch drivers on the outputs
`timescale 1ns/1ps
module power_switch_model (
  input wire [3:0] i_drive,
  input wire [3:0] i_pol,
  output wire [3:0] o_on
);
  // a driver conducts when its pin sits at the active level chosen by polarity
  assign o_on = i_drive ^ i_pol;
endmodule

/* File: testbench/testbench.sv */
// self-checking bench for the waveform unit
`timescale 1ns/1ps
`include "cwg_map.vh"
module testbench;
  logic clk = 1'b0;
  logic rst_n;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic data;
  logic shut;
  logic ce;
  logic [3:0] pol_v;
  logic [7:0] s;
  logic [3:0] p;
  logic d;
  wire [7:0] rdata;
  wire [3:0] outs;
  wire [3:0] on;
  integer seed = 32'h7dbb;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  int i;

  always #10 clk = ~clk;

  complementary_wave_unit complementary_wave_unit_inst (
    .i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_data(data), .i_shutdown(shut),
    .o_out_a(outs[0]), .o_out_b(outs[1]), .o_out_c(outs[2]), .o_out_d(outs[3]));
  power_switch_model power_switch_model_inst (.i_drive(outs), .i_pol(pol_v), .o_on(on));

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      complete_run;
    end
  end

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    if (a == `CWG_ADDR_POL) pol_v <= v[3:0];
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  // read data stands only in the cycle after the strobe, so it is sampled 1 ns after the edge that takes the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("read data", rdata, exp);
    @(posedge clk);
  endtask

  task automatic chk_on(input string name, input logic [3:0] exp);
    @(negedge clk);
    chk(name, {4'h0, on}, {4'h0, exp});
    @(posedge clk);
  endtask

  task automatic pulse_chk(input logic [3:0] exp);
    data <= 1'b1;
    tick(2);
    chk_on("push pull", exp);
    data <= 1'b0;
    tick(2);
  endtask

  function automatic logic [3:0] steer_exp(input logic [7:0] st, input logic [3:0] pl,
      input logic dv);
    return (st[3:0] & ({4{dv}} ^ pl)) | (~st[3:0] & st[7:4]);
  endfunction

  initial begin
    rst_n = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    data = 1'b0;
    shut = 1'b0;
    ce = 1'b1;
    pol_v = 4'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_chk(`CWG_ADDR_STAT, 8'h10);
    wr_reg(`CWG_ADDR_STAT, 8'hFF);
    rd_chk(`CWG_ADDR_STAT, 8'h10);
    rd_chk(4'hA, 8'h00);
    wr_reg(`CWG_ADDR_CTRL, 8'h80);
    for (i = 0; i < 8; i++) begin
      {s, p, d} = 13'($random(seed));
      wr_reg(`CWG_ADDR_POL, {4'h0, p});
      wr_reg(`CWG_ADDR_STEER, s);
      data <= d;
      shut <= (i == 5);
      tick(3);
      chk_on("async steer", (i == 5) ? p : steer_exp(s, p, d) ^ p);
    end
    // sync steering: steer bits wait for an input rise, static levels do not
    wr_reg(`CWG_ADDR_STEER, 8'h00);
    wr_reg(`CWG_ADDR_POL, 8'h00);
    wr_reg(`CWG_ADDR_CTRL, 8'h00);
    data <= 1'b1;
    wr_reg(`CWG_ADDR_CTRL, 8'h81);
    wr_reg(`CWG_ADDR_STEER, 8'h81);
    tick(2);
    chk_on("sync hold", 4'h8);
    data <= 1'b0;
    tick(2);
    data <= 1'b1;
    tick(3);
    chk_on("sync take", 4'h9);
    wr_reg(`CWG_ADDR_CTRL, 8'h00);
    wr_reg(`CWG_ADDR_DBR, 8'h03);
    wr_reg(`CWG_ADDR_CTRL, 8'h82);
    tick(3);
    chk_on("forward", 4'h9);
    wr_reg(`CWG_ADDR_CTRL, 8'h83);
    tick(4);
    chk_on("before rise", 4'h9);
    data <= 1'b0;
    tick(1);
    data <= 1'b1;
    tick(2);
    chk_on("reverse dead band", 4'h4);
    tick(3);
    chk_on("reverse", 4'h6);
    wr_reg(`CWG_ADDR_CTRL, 8'h00);
    wr_reg(`CWG_ADDR_CTRL, 8'h83);
    tick(2);
    chk_on("reverse at enable", 4'h6);
    data <= 1'b0;
    wr_reg(`CWG_ADDR_CTRL, 8'h00);
    wr_reg(`CWG_ADDR_CTRL, 8'h85);
    tick(2);
    for (i = 0; i < 3; i++) pulse_chk(i[0] ? 4'hA : 4'h5);
    shut <= 1'b1;
    tick(2);
    chk_on("shutdown", 4'h0);
    shut <= 1'b0;
    tick(2);
    pulse_chk(4'h5);
    wr_reg(`CWG_ADDR_CTRL, 8'h00);
    wr_reg(`CWG_ADDR_POL, 8'h04);
    wr_reg(`CWG_ADDR_CTRL, 8'h84);
    tick(6);
    chk_on("half low", 4'hA);
    data <= 1'b1;
    tick(2);
    chk_on("half dead band", 4'h0);
    tick(4);
    chk_on("half high", 4'h5);
    // clock enable low: every flop holds although the input falls
    ce <= 1'b0;
    data <= 1'b0;
    tick(3);
    chk_on("frozen", 4'h5);
    ce <= 1'b1;
    tick(2);
    chk_on("half after freeze", 4'hA);
    wr_reg(`CWG_ADDR_CTRL, 8'h00);
    wr_reg(`CWG_ADDR_CTRL, 8'h86);
    data <= 1'b1;
    tick(3);
    chk_on("reserved mode", 4'h0);
    complete_run;
  end
endmodule
